// ==== src/tsr_pkg.sv ====
// Shared constants for the tape status and recovery link
package tsr_pkg;
  typedef logic [2:0] tsr_code_t;
  localparam tsr_code_t FN_NONE = 3'h0;
  localparam tsr_code_t FN_BOOT = 3'h1;
  localparam tsr_code_t FN_WRITE = 3'h2;
  localparam tsr_code_t FN_SKIPWRITE = 3'h3;
  localparam tsr_code_t FN_SKIPONLY = 3'h4;
  localparam tsr_code_t FN_READFWD = 3'h5;
  localparam tsr_code_t FN_READBWD = 3'h6;
  localparam tsr_code_t FN_REWIND = 3'h7;
  // Function word fields
  localparam int FW_CODE_LSB = 0;
  localparam int FW_CODE_MSB = 2;
  localparam int FW_TRACK_LSB = 5;
  localparam int FW_TRACK_MSB = 8;
  localparam int CMD_POS_BIT = 9;
  localparam int CMD_GO_BIT = 31;
  // Status word fields
  localparam int ST_FC_LSB = 0;
  localparam int ST_FC_MSB = 3;
  localparam int ST_ABN = 4;
  localparam int ST_BT_LSB = 5;
  localparam int ST_BT_MSB = 8;
  localparam int ST_PAR = 9;
  localparam int ST_LATE = 10;
  localparam int ST_EOF = 11;
  localparam int ST_HASH = 12;
  localparam int ST_EOT = 13;
  localparam int ST_BUSY = 14;
  localparam int ST_ILK = 15;
  localparam int ST_INV = 16;
  localparam int ST_LDP = 17;
  // Frame handling
  localparam logic [8:0] EOF_FRAME = 9'h013;
  localparam logic [3:0] FC_LAST = 4'he;
  localparam logic [3:0] TRACKS = 4'h9;
  localparam logic [7:0] WORDS_FULL = 8'h04;
  localparam logic [7:0] WORDS_SHORT = 8'h03;
  localparam logic [2:0] MAX_RETRY = 3'h3;
  // Controller registers over AXI4-Lite
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_WORDS = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_STATE = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SS_BUSY = 0;
  localparam int SS_DONE = 1;
  localparam int SS_ERR = 2;
  localparam int SS_EOF = 3;
  localparam int SS_EOT = 4;
  localparam int SS_RTY_LSB = 5;
  localparam int SS_RTY_MSB = 7;
  localparam int SS_BT_LSB = 8;
  localparam int SS_BT_MSB = 11;
endpackage : tsr_pkg

// ==== src/tsr_if.sv ====
// Function word and status word link between host and tape device
`timescale 1ns/10ps
interface tsr_if (
  input wire logic aclk
);
  logic func_valid;
  logic [31:0] func_word;
  logic [31:0] status_word;
  logic status_ready_interrupt;
  modport dev (
    input func_valid,
    input func_word,
    output status_word,
    output status_ready_interrupt
  );
  modport host (
    output func_valid,
    output func_word,
    input status_word,
    input status_ready_interrupt
  );
endinterface : tsr_if

// ==== src/tsr_device.sv ====
// Tape device end: runs one function and reports its status word
`timescale 1ns/10ps
module tsr_device (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to host
  tsr_if.dev lnk,
  // Tape transport side
  output logic motion_start,
  output tsr_pkg::tsr_code_t motion_code,
  input wire logic frame_valid,
  input wire logic [8:0] frame_data,
  input wire logic block_end,
  input wire logic diag_err,
  input wire logic late_ack,
  input wire logic tape_hash,
  input wire logic eot_warn,
  input wire logic unit_busy,
  input wire logic interlock,
  input wire logic load_point
);
  import tsr_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_RUN, D_REPORT} tsr_dstate_e;

  function automatic logic [3:0] first_bad(input logic [8:0] lrc);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (lrc[i]) begin
        idx = 4'(i + 1);
      end
    end
    return idx;
  endfunction : first_bad

  tsr_dstate_e state_reg, state_next;
  tsr_code_t code_reg, code_next;
  logic [8:0] lrc_reg, lrc_next;
  logic [8:0] first_reg, first_next;
  logic [1:0] nfr_reg, nfr_next;
  logic [3:0] fc_reg, fc_next;
  logic lat_reg, lat_next;
  logic diag_reg, diag_next;
  logic late_reg, late_next;
  logic inv_reg, inv_next;
  logic ilk_reg, ilk_next;
  logic [31:0] status_reg, status_next;
  logic irq_reg, irq_next;
  logic start_reg, start_next;

  logic is_read, par, eof;
  logic [3:0] bad;

  always_comb begin
    state_next = state_reg;
    code_next = code_reg;
    lrc_next = lrc_reg;
    first_next = first_reg;
    nfr_next = nfr_reg;
    fc_next = fc_reg;
    lat_next = lat_reg;
    diag_next = diag_reg;
    late_next = late_reg;
    inv_next = inv_reg;
    ilk_next = ilk_reg;
    status_next = status_reg;
    irq_next = 1'b0;
    start_next = 1'b0;
    // Bootstrap reads like a forward read from load point
    is_read = (code_reg == FN_READFWD) || (code_reg == FN_READBWD) || (code_reg == FN_BOOT);
    bad = is_read ? first_bad(lrc_reg) : 4'h0;
    par = lat_reg || diag_reg || (|lrc_reg) || (bad != 4'h0);
    eof = is_read && (nfr_reg == 2'h1) && (first_reg == EOF_FRAME);
    case (state_reg)
      D_IDLE: begin
        if (lnk.func_valid) begin
          code_next = lnk.func_word[FW_CODE_MSB:FW_CODE_LSB];
          lrc_next = 9'h000;
          first_next = 9'h000;
          nfr_next = 2'h0;
          fc_next = 4'h0;
          lat_next = 1'b0;
          diag_next = 1'b0;
          late_next = 1'b0;
          inv_next = (lnk.func_word[FW_CODE_MSB:FW_CODE_LSB] == FN_NONE);
          ilk_next = interlock;
          if (interlock || (lnk.func_word[FW_CODE_MSB:FW_CODE_LSB] == FN_NONE)) begin
            state_next = D_REPORT;
          end else begin
            start_next = 1'b1;
            state_next = D_RUN;
          end
        end
      end
      D_RUN: begin
        if (frame_valid) begin
          lrc_next = lrc_reg ^ frame_data;
          lat_next = lat_reg || !(^frame_data);
          if (nfr_reg == 2'h0) begin
            first_next = frame_data;
          end
          if (nfr_reg != 2'h2) begin
            nfr_next = nfr_reg + 2'h1;
          end
          fc_next = (fc_reg == FC_LAST) ? 4'h0 : fc_reg + 4'h1;
        end
        late_next = late_reg || late_ack;
        if (block_end) begin
          diag_next = diag_err && !frame_valid;
          state_next = D_REPORT;
        end
      end
      D_REPORT: begin
        status_next = 32'h0000_0000;
        status_next[ST_FC_MSB:ST_FC_LSB] = is_read ? fc_reg : 4'h0;
        status_next[ST_ABN] = is_read && (fc_reg != 4'h0);
        status_next[ST_BT_MSB:ST_BT_LSB] = bad;
        status_next[ST_PAR] = par && !inv_reg && !ilk_reg;
        status_next[ST_LATE] = late_reg;
        status_next[ST_EOF] = eof;
        status_next[ST_HASH] = tape_hash && !is_read;
        status_next[ST_EOT] = eot_warn;
        status_next[ST_BUSY] = unit_busy;
        status_next[ST_ILK] = ilk_reg;
        status_next[ST_INV] = inv_reg;
        status_next[ST_LDP] = load_point;
        irq_next = 1'b1;
        state_next = D_IDLE;
      end
      default: begin
        state_next = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= D_IDLE;
      code_reg <= FN_NONE;
      lrc_reg <= 9'h000;
      first_reg <= 9'h000;
      nfr_reg <= 2'h0;
      fc_reg <= 4'h0;
      lat_reg <= 1'b0;
      diag_reg <= 1'b0;
      late_reg <= 1'b0;
      inv_reg <= 1'b0;
      ilk_reg <= 1'b0;
      status_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      lrc_reg <= lrc_next;
      first_reg <= first_next;
      nfr_reg <= nfr_next;
      fc_reg <= fc_next;
      lat_reg <= lat_next;
      diag_reg <= diag_next;
      late_reg <= late_next;
      inv_reg <= inv_next;
      ilk_reg <= ilk_next;
      status_reg <= status_next;
      irq_reg <= irq_next;
      start_reg <= start_next;
    end
  end

  assign lnk.status_word = status_reg;
  assign lnk.status_ready_interrupt = irq_reg;
  assign motion_start = start_reg;
  assign motion_code = code_reg;
endmodule : tsr_device

// ==== src/tsr_host.sv ====
// Host end: issues functions, applies recovery, AXI4-Lite register slave
// Overview of operation
// - Bootstrap reports like rewind plus forward read
// - Bootstrap error: only reissue the bootstrap
// - Write priority: hash, late, parity, warning
// - Keep end-of-tape warning during any recovery
// - Write parity covers lateral, longitudinal, diagonal
// - Write parity: read backward, then rewrite
// - Data read priority: eof, late, parity, counts
// - Pass read priority: eof, parity, late
// - Pass read: ignore late, long parity noise
// - Pass parity+late, few words: backward then forward
// - Read parity covers lateral, longitudinal, diagonal
// - Short block parity without late: reissue read
// - Long block parity: save track, backward, reread
// - Retry track field: saved value or zeros
// - Long block passed with parity: ignore it
// - Nonzero bad track forces parity indicator
// - Status word delivered with an interrupt
// - Single frame 000010011 means end-of-file
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module tsr_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to device
  tsr_if.host lnk,
  // AXI4-Lite write channels
  input wire logic [tsr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [tsr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tsr_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_ISSUE, H_WAIT, H_DECIDE, H_BACK, H_BACK_WAIT} tsr_hstate_e;
  typedef enum logic [1:0] {A_DONE, A_FAIL, A_RETRY, A_BACK} tsr_act_e;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  tsr_hstate_e state_reg, state_next;
  logic [31:0] cmd_reg, cmd_next;
  logic [31:0] words_reg, words_next;
  logic [31:0] fword_reg, fword_next;
  logic [31:0] stat_reg, stat_next;
  logic [3:0] saved_bt_reg, saved_bt_next;
  logic [2:0] rty_reg, rty_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic eof_reg, eof_next;
  logic eot_reg, eot_next;
  logic aw_hold_reg, aw_hold_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  tsr_act_e act;
  tsr_code_t code;
  logic pos, big12, do_write, start;
  logic [31:0] state_word;

  // Recovery decision from the latched status word
  always_comb begin
    code = fword_reg[FW_CODE_MSB:FW_CODE_LSB];
    pos = cmd_reg[CMD_POS_BIT];
    big12 = (words_reg[7:0] >= WORDS_FULL) ||
            ((words_reg[7:0] == WORDS_SHORT) && (stat_reg[ST_FC_MSB:ST_FC_LSB] == 4'h0));
    act = A_DONE;
    if (stat_reg[ST_ILK] || stat_reg[ST_INV]) begin
      act = A_FAIL;
    end else begin
      case (code)
        FN_BOOT: begin
          if (stat_reg[ST_PAR] || stat_reg[ST_LATE] || stat_reg[ST_HASH] || stat_reg[ST_ABN]) begin
            act = A_RETRY;
          end
        end
        FN_WRITE, FN_SKIPWRITE, FN_SKIPONLY: begin
          if (stat_reg[ST_HASH] || stat_reg[ST_LATE]) begin
            act = A_FAIL;
          end else if (stat_reg[ST_PAR]) begin
            act = (code != FN_SKIPONLY && !eot_reg) ? A_BACK : A_FAIL;
          end
        end
        FN_READFWD: begin
          if (stat_reg[ST_EOF]) begin
            act = A_DONE;
          end else if (!pos) begin
            if (stat_reg[ST_LATE]) begin
              act = A_FAIL;
            end else if (stat_reg[ST_PAR]) begin
              act = big12 ? A_BACK : A_RETRY;
            end else if (stat_reg[ST_ABN] || (stat_reg[ST_FC_MSB:ST_FC_LSB] != 4'h0)) begin
              act = A_FAIL;
            end
          end else if (stat_reg[ST_PAR]) begin
            if (stat_reg[ST_LATE] && (words_reg[7:0] <= WORDS_SHORT)) begin
              act = A_BACK;
            end else if (!big12) begin
              act = A_RETRY;
            end else begin
              act = A_DONE;
            end
          end
        end
        default: begin
          act = A_DONE;
        end
      endcase
    end
    if ((act == A_RETRY || act == A_BACK) && (rty_reg == MAX_RETRY)) begin
      act = A_FAIL;
    end
  end

  always_comb begin
    state_word = 32'h0000_0000;
    state_word[SS_BUSY] = (state_reg != H_IDLE);
    state_word[SS_DONE] = done_reg;
    state_word[SS_ERR] = err_reg;
    state_word[SS_EOF] = eof_reg;
    state_word[SS_EOT] = eot_reg;
    state_word[SS_RTY_MSB:SS_RTY_LSB] = rty_reg;
    state_word[SS_BT_MSB:SS_BT_LSB] = saved_bt_reg;
    do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    start = do_write && (awaddr_reg == REG_CMD) && wstrb_reg[3] && wdata_reg[CMD_GO_BIT] && (state_reg == H_IDLE);
  end

  // Register slave and function sequencer
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    words_next = words_reg;
    fword_next = fword_reg;
    stat_next = stat_reg;
    saved_bt_next = saved_bt_reg;
    rty_next = rty_reg;
    done_next = done_reg;
    err_next = err_reg;
    eof_next = eof_reg;
    eot_next = eot_reg;
    aw_hold_next = aw_hold_reg;
    awaddr_next = awaddr_reg;
    w_hold_next = w_hold_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (awaddr_reg)
        REG_CMD: begin
          if (state_reg == H_IDLE) begin
            cmd_next = merge(cmd_reg, wdata_reg, wstrb_reg);
          end
        end
        REG_WORDS: begin
          words_next = merge(words_reg, wdata_reg, wstrb_reg);
        end
        REG_STATUS, REG_STATE: begin
          bresp_next = RESP_OKAY;
        end
        default: begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (s_axi_araddr)
        REG_CMD: rdata_next = cmd_reg;
        REG_WORDS: rdata_next = words_reg;
        REG_STATUS: rdata_next = stat_reg;
        REG_STATE: rdata_next = state_word;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    if (lnk.status_ready_interrupt && lnk.status_word[ST_EOT]) begin
      eot_next = 1'b1;
    end
    case (state_reg)
      H_IDLE: begin
        if (start) begin
          fword_next = merge(cmd_reg, wdata_reg, wstrb_reg);
          fword_next[CMD_GO_BIT] = 1'b0;
          rty_next = 3'h0;
          done_next = 1'b0;
          err_next = 1'b0;
          eof_next = 1'b0;
          eot_next = 1'b0;
          state_next = H_ISSUE;
        end
      end
      H_ISSUE: begin
        state_next = H_WAIT;
      end
      H_WAIT: begin
        if (lnk.status_ready_interrupt) begin
          stat_next = lnk.status_word;
          state_next = H_DECIDE;
        end
      end
      H_DECIDE: begin
        case (act)
          A_RETRY: begin
            rty_next = rty_reg + 3'h1;
            state_next = H_ISSUE;
          end
          A_BACK: begin
            rty_next = rty_reg + 3'h1;
            if (code == FN_READFWD && !pos) begin
              saved_bt_next = stat_reg[ST_BT_MSB:ST_BT_LSB];
              fword_next[FW_TRACK_MSB:FW_TRACK_LSB] =
                (fword_reg[FW_TRACK_MSB:FW_TRACK_LSB] == 4'h0) ? stat_reg[ST_BT_MSB:ST_BT_LSB] : 4'h0;
            end
            state_next = H_BACK;
          end
          default: begin
            done_next = 1'b1;
            err_next = (act == A_FAIL);
            eof_next = stat_reg[ST_EOF];
            state_next = H_IDLE;
          end
        endcase
      end
      H_BACK: begin
        state_next = H_BACK_WAIT;
      end
      H_BACK_WAIT: begin
        if (lnk.status_ready_interrupt) begin
          state_next = H_ISSUE;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= H_IDLE;
      cmd_reg <= 32'h0000_0000;
      words_reg <= 32'h0000_0000;
      fword_reg <= 32'h0000_0000;
      stat_reg <= 32'h0000_0000;
      saved_bt_reg <= 4'h0;
      rty_reg <= 3'h0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      eof_reg <= 1'b0;
      eot_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      awaddr_reg <= REG_CMD;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      words_reg <= words_next;
      fword_reg <= fword_next;
      stat_reg <= stat_next;
      saved_bt_reg <= saved_bt_next;
      rty_reg <= rty_next;
      done_reg <= done_next;
      err_reg <= err_next;
      eof_reg <= eof_next;
      eot_reg <= eot_next;
      aw_hold_reg <= aw_hold_next;
      awaddr_reg <= awaddr_next;
      w_hold_reg <= w_hold_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Backward read word carries no track field
  assign lnk.func_valid = (state_reg == H_ISSUE) || (state_reg == H_BACK);
  assign lnk.func_word = (state_reg == H_BACK) ? {29'h0000_0000, FN_READBWD} : fword_reg;
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule : tsr_host

// ==== tb/tsr_link_assertions.sv ====
// Concurrent checks on the host to device function link
`timescale 1ns/10ps
module tsr_link_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic func_valid,
  input wire logic [31:0] func_word,
  input wire logic [31:0] status_word,
  input wire logic status_ready_interrupt
);
  import tsr_pkg::*;
  logic outst_reg, outst_next, rfail_reg, rfail_next;
  tsr_code_t code_reg, code_next;
  logic [3:0] rtrk_reg, rtrk_next, rbt_reg, rbt_next;
  always_comb begin
    outst_next = outst_reg;
    code_next = code_reg;
    rtrk_next = rtrk_reg;
    rbt_next = rbt_reg;
    rfail_next = rfail_reg;
    if (func_valid) begin
      outst_next = 1'b1;
      code_next = func_word[2:0];
      if (func_word[2:0] == FN_READFWD) rtrk_next = func_word[8:5];
    end
    if (status_ready_interrupt) begin
      outst_next = 1'b0;
      if (code_reg == FN_READFWD) begin
        rbt_next = status_word[ST_BT_MSB:ST_BT_LSB];
        rfail_next = status_word[ST_PAR] && !status_word[ST_LATE];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outst_reg <= 1'b0;
      code_reg <= FN_NONE;
      rtrk_reg <= 4'h0;
      rbt_reg <= 4'h0;
      rfail_reg <= 1'b0;
    end else begin
      outst_reg <= outst_next;
      code_reg <= code_next;
      rtrk_reg <= rtrk_next;
      rbt_reg <= rbt_next;
      rfail_reg <= rfail_next;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_bwd_issue;
    ##[1:8] (func_valid && func_word[2:0] == FN_READBWD);
  endsequence
  sequence s_quiet;
    (!func_valid) [*8];
  endsequence
  AST_IRQ_PULSE: assert property (status_ready_interrupt |=> !status_ready_interrupt)
    else $error("interrupt longer than one cycle");
  AST_ONE_OUT: assert property (func_valid |-> !outst_reg)
    else $error("function issued before previous status");
  AST_INV_ANS: assert property (func_valid && func_word[2:0] == FN_NONE |-> ##2 (status_ready_interrupt && status_word[ST_INV]))
    else $error("invalid function not reported in time");
  AST_BT_PAR: assert property (status_ready_interrupt && status_word[8:5] != 4'h0 |-> status_word[ST_PAR])
    else $error("bad track without parity");
  AST_BOOT_RETRY: assert property (status_ready_interrupt && code_reg == FN_BOOT && (status_word[ST_PAR] ||
    status_word[ST_LATE] || status_word[ST_HASH] || status_word[ST_ABN]) |-> ##1
    (!(func_valid && func_word[2:0] != FN_BOOT)) [*6])
    else $error("bootstrap error followed by other function");
  AST_WPAR_BWD: assert property (status_ready_interrupt && (code_reg == FN_WRITE || code_reg == FN_SKIPWRITE) &&
    status_word[ST_PAR] && !status_word[ST_HASH] && !status_word[ST_LATE] && !status_word[ST_EOT] |-> s_bwd_issue)
    else $error("write parity without backward read");
  AST_HASH_STOP: assert property (status_ready_interrupt && code_reg == FN_WRITE && status_word[ST_HASH] |-> ##1 s_quiet)
    else $error("function issued after tape hash");
  AST_TRK_RETRY: assert property (func_valid && func_word[2:0] == FN_READFWD && code_reg == FN_READBWD && rfail_reg
    |-> func_word[8:5] == (rtrk_reg == 4'h0 ? rbt_reg : 4'h0))
    else $error("retry track field wrong");
endmodule : tsr_link_assertions

// ==== tb/tape_status_error_recovery_test.sv ====
// Bench for host and device ends joined by the link
`timescale 1ns/10ps
module tape_status_error_recovery_test;
  import tsr_pkg::*;
  typedef struct {logic [31:0] cmd; logic [7:0] words; tsr_code_t ecode; logic ekind; logic eof; logic [3:0] lv;
    logic [7:0] st; logic [8:0] sv; logic [8:0] sm; int n; logic [11:0] seq;} tsr_row_s;
  logic aclk = 0, aresetn = 0, frame_valid = 0, block_end = 0, diag_err = 0, tape_hash = 0, eot_warn = 0;
  logic interlock = 0, motion_start, err_left = 0, hit;
  logic [8:0] frame_data = 9'h000;
  tsr_code_t motion_code;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch = 0, comparisons = 0;
  tsr_code_t codes[$];
  tsr_row_s cur;
  tsr_row_s rows[13] = '{
    '{32'h8000_0005, 8'h04, FN_NONE, 0, 0, 4'h0, 8'h02, 9'h000, 9'h1ff, 1, 12'h005},
    '{32'h8000_0005, 8'h04, FN_NONE, 0, 1, 4'h0, 8'h0a, 9'h004, 9'h004, 1, 12'h005},
    '{32'h8000_0002, 8'h04, FN_WRITE, 0, 0, 4'h0, 8'h22, 9'h000, 9'h1ff, 3, 12'h0b2},
    '{32'h8000_0005, 8'h02, FN_READFWD, 0, 0, 4'h0, 8'h22, 9'h000, 9'h1ff, 2, 12'h02d},
    '{32'h8000_0205, 8'h04, FN_READFWD, 0, 0, 4'h0, 8'h02, 9'h001, 9'h1ff, 1, 12'h005},
    '{32'h8000_0001, 8'h04, FN_BOOT, 0, 0, 4'h0, 8'h22, 9'h000, 9'h1ff, 2, 12'h009},
    '{32'h8000_0001, 8'h04, FN_NONE, 0, 0, 4'h4, 8'h06, 9'h040, 9'h1ff, 0, 12'h000},
    '{32'h8000_0002, 8'h04, FN_WRITE, 0, 0, 4'h1, 8'h06, 9'h009, 9'h1ff, 1, 12'h002},
    '{32'h8000_0000, 8'h04, FN_NONE, 0, 0, 4'h0, 8'h06, 9'h080, 9'h1ff, 0, 12'h000},
    '{32'h8000_0205, 8'h03, FN_READFWD, 0, 0, 4'h8, 8'h22, 9'h000, 9'h1ff, 3, 12'h175},
    '{32'h8000_0002, 8'h04, FN_NONE, 0, 0, 4'h2, 8'h12, 9'h010, 9'h1ff, 1, 12'h002},
    '{32'h8000_0002, 8'h04, FN_WRITE, 0, 0, 4'h2, 8'h16, 9'h011, 9'h1ff, 1, 12'h002},
    '{32'h8000_0005, 8'h04, FN_READFWD, 1, 0, 4'h0, 8'h22, 9'h000, 9'h1ff, 3, 12'h175}};
  tsr_if link (.aclk(aclk));
  tsr_host tsr_host_i (.aclk(aclk), .aresetn(aresetn), .lnk(link), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  tsr_device tsr_device_i (.aclk(aclk), .aresetn(aresetn), .lnk(link), .motion_start(motion_start),
    .motion_code(motion_code), .frame_valid(frame_valid), .frame_data(frame_data), .block_end(block_end),
    .diag_err(diag_err), .late_ack(diag_err && cur.lv[3]), .tape_hash(tape_hash), .eot_warn(eot_warn),
    .unit_busy(1'b0), .interlock(interlock), .load_point(1'b0));
  tsr_link_assertions tsr_link_assertions_i (.aclk(aclk), .aresetn(aresetn), .func_valid(link.func_valid),
    .func_word(link.func_word), .status_word(link.status_word), .status_ready_interrupt(link.status_ready_interrupt));
  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s at %0t: got %h want %h", what, $time, got, exp);
    end
  endtask : cmp
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    cmp(s_axi_bresp, RESP_OKAY, "bresp");
  endtask : axi_wr
  task axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 0;
  endtask : axi_rd
  initial forever #12.5 aclk = ~aclk;
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    close_out;
  end
  // Tape transport: clean 30 frame block (one EOF frame on eof rows), one faulted pass on the chosen function
  initial forever begin
    @(posedge aclk);
    if (motion_start === 1'b1) begin
      hit = err_left && motion_code === cur.ecode;
      codes.push_back(motion_code);
      if (hit) err_left = 0;
      for (int i = 0; i < (cur.eof ? 1 : 30); i++) begin
        frame_valid <= 1;
        frame_data <= cur.eof ? EOF_FRAME : (hit && cur.ekind && i == 3) ? 9'h003 : 9'h001;
        @(posedge aclk);
      end
      frame_valid <= 0; block_end <= 1; diag_err <= hit && !cur.ekind;
      @(posedge aclk);
      block_end <= 0; diag_err <= 0;
    end
  end
  initial begin
    logic [11:0] got;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    axi_rd(REG_STATE, rd);
    cmp(rd, 32'h0, "state reset");
    foreach (rows[r]) begin
      cur = rows[r];
      codes.delete();
      tape_hash <= cur.lv[0]; eot_warn <= cur.lv[1]; interlock <= cur.lv[2];
      err_left = cur.ecode != FN_NONE;
      axi_wr(REG_WORDS, {24'h0, cur.words});
      axi_wr(REG_CMD, cur.cmd);
      rd = 32'h0;
      for (int k = 0; k < 400 && !(rd[SS_DONE] | rd[SS_ERR]); k++) axi_rd(REG_STATE, rd);
      cmp(rd[7:0], cur.st, "state");
      axi_rd(REG_STATUS, rd);
      cmp(rd[17:9] & cur.sm, cur.sv & cur.sm, "status");
      got = 12'h0;
      foreach (codes[c]) got = got | (12'(codes[c]) << (3 * c));
      cmp(codes.size(), cur.n, "function count");
      cmp(got, cur.seq, "function order");
    end
    axi_rd(REG_STATE, rd);
    cmp(rd[SS_BT_MSB:SS_BT_LSB], 4'h2, "saved track");
    close_out;
  end
endmodule : tape_status_error_recovery_test
